// ---- core/tei_regs.vh ----
// Constants for the terminal escape interpreter: characters, sizes, codes.
// Assumes ASCII7 characters arriving one per valid/ready handshake.
`ifndef TEI_REGS_VH
`define TEI_REGS_VH

`define TEI_CH_ENQ      7'h05
`define TEI_CH_ACK      7'h06
`define TEI_CH_BEL      7'h07
`define TEI_CH_BS       7'h08
`define TEI_CH_LF       7'h0a
`define TEI_CH_CR       7'h0d
`define TEI_CH_ESC      7'h1b
`define TEI_CH_LBR      7'h5b
`define TEI_CH_SEMI     7'h3b
`define TEI_CH_ZERO     7'h30
`define TEI_CH_NINE     7'h39
`define TEI_CH_SAVE     7'h37
`define TEI_CH_REST     7'h38
`define TEI_CH_UP       7'h41
`define TEI_CH_DOWN     7'h42
`define TEI_CH_RIGHT    7'h43
`define TEI_CH_LEFT     7'h44
`define TEI_CH_POSH     7'h48
`define TEI_CH_POSF     7'h66
`define TEI_CH_ESCR     7'h4a
`define TEI_CH_ERLN     7'h4b
`define TEI_CH_IDX      7'h44
`define TEI_CH_NEL      7'h45
`define TEI_CH_RIDX     7'h4d
`define TEI_CH_RIS      7'h63

`define TEI_COLS        7'h50
`define TEI_ROWS        5'h18
`define TEI_SCREENS     2'h3

// Blank operation codes
`define TEI_CLR_NONE    3'h0
`define TEI_CLR_SCR_END 3'h1
`define TEI_CLR_SCR_BEG 3'h2
`define TEI_CLR_SCR_ALL 3'h3
`define TEI_CLR_LN_END  3'h4
`define TEI_CLR_LN_BEG  3'h5
`define TEI_CLR_LN_ALL  3'h6

`endif

// ---- core/tei_interpreter.v ----
// What this block does
// - ENQ sends ACK; BEL beeps; BS, LF, CR move the cursor.
// - Other control characters except ESC are dropped with no effect.
// - Sequences with numbers are ESC, open bracket, parameters, final letter.
// - ESC[nA moves up n rows, same column, never scrolls.
// - ESC[nB moves down n rows, same column, never scrolls.
// - ESC[nC moves right n columns; stays put at right edge.
// - ESC[nD moves left n columns; stays put at left edge.
// - ESC[r;cH or f places cursor one-based, clamped to 24 and 80.
// - ESC[nJ blanks to end, from start, or whole screen.
// - ESC[nK blanks to line end, from line start, or whole line.
// - ESC 7 saves cursor position; ESC 8 restores it.
// - ESC D moves down; scrolls on last row unless fourth screen.
// - ESC E moves to column one of next row.
// - ESC M moves up; scrolls back on top row unless first screen.
// - ESC c resets to power-on state and requests self test.
// - Screen is 80 columns by 24 rows; cursor bounded by them.
// - Buffer holds 96 rows, four screens; scrolling moves the window.
// - At reset the screen is cleared and cursor set to row 1, col 1.
//
// Interprets received characters; drives cursor, window and blank requests.
// Assumes the display memory acts on clearOp with the cursor shown.
`timescale 1ns/1ns
`include "tei_regs.vh"

module tei_interpreter #(
   parameter PW = 7
)(
   // Clock and reset
   input  wire        clk,
   input  wire        reset_n,
   // Received characters
   input  wire [6:0]  rxChar,
   input  wire        rxValid,
   output reg         rxReady,
   // Characters to transmit
   output reg  [6:0]  txChar,
   output reg         txValid,
   input  wire        txReady,
   // Display control
   output reg  [4:0]  cursorRow,
   output reg  [6:0]  cursorCol,
   output reg  [1:0]  screenSel,
   output reg  [2:0]  clearOp,
   output reg         beep,
   output reg         selfTest
);

   localparam ST_IDLE = 2'h0;
   localparam ST_ESC  = 2'h1;
   localparam ST_CSI  = 2'h2;

   // ----------------------------------------------------------------
   // Two-entry input buffer
   // ----------------------------------------------------------------
   // Two slots so a full-rate sender keeps ready high while we consume.
   reg  [6:0] buf0_q, buf1_q;
   reg  [1:0] cnt_q;
   // A pending ACK holds the head so replies keep the input order
   wire       txBusy = txValid && !txReady;
   wire       take   = (cnt_q != 2'h0) && !txBusy;
   wire       push   = rxValid && rxReady;
   wire [6:0] ch     = buf0_q;

   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         buf0_q  <= 7'h00;
         buf1_q  <= 7'h00;
         cnt_q   <= 2'h0;
         rxReady <= 1'b0;
      end
      else
      begin
         case ({push, take})
            2'b10:
            begin
               if (cnt_q == 2'h0) buf0_q <= rxChar;
               else buf1_q <= rxChar;
               cnt_q <= cnt_q + 2'h1;
            end
            2'b01:
            begin
               buf0_q <= buf1_q;
               cnt_q  <= cnt_q - 2'h1;
            end
            2'b11:
            begin
               if (cnt_q == 2'h1) buf0_q <= rxChar;
               else
               begin
                  buf0_q <= buf1_q;
                  buf1_q <= rxChar;
               end
            end
            default: ;
         endcase
         // Registered ready looks one push ahead of the count
         rxReady <= (cnt_q == 2'h0) || (cnt_q == 2'h1 && !(push && !take))
                    || (cnt_q == 2'h2 && take && !push);
      end
   end

   // ----------------------------------------------------------------
   // Interpreter
   // ----------------------------------------------------------------
   reg  [1:0]    st_q;
   reg  [PW-1:0] p1_q, p2_q;
   reg           p1Seen_q, semi_q;
   reg  [4:0]    saveRow_q;
   reg  [6:0]    saveCol_q;

   // Digits build p1 up to the separator, then p2
   wire isDigit = (ch >= `TEI_CH_ZERO) && (ch <= `TEI_CH_NINE);
   wire [3:0] dig = ch[3:0];
   // Move count: missing or zero reads as one
   wire [PW-1:0] cnt = (p1_q == {PW{1'b0}}) ?
                       {{(PW-1){1'b0}}, 1'b1} : p1_q;
   wire [7:0] cntW = {{(8-PW){1'b0}}, cnt};
   wire [7:0] rowW = {3'h0, cursorRow};
   wire [7:0] colW = {1'h0, cursorCol};
   wire [7:0] p1W  = {{(8-PW){1'b0}}, p1_q};
   wire [7:0] p2W  = {{(8-PW){1'b0}}, p2_q};
   wire [PW+3:0] accA = {p1_q, 3'h0} + {2'h0, p1_q, 1'b0} + {{PW{1'b0}}, dig};
   wire [PW+3:0] accB = {p2_q, 3'h0} + {2'h0, p2_q, 1'b0} + {{PW{1'b0}}, dig};

   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         st_q      <= ST_IDLE;
         p1_q      <= {PW{1'b0}};
         p2_q      <= {PW{1'b0}};
         p1Seen_q  <= 1'b0;
         semi_q    <= 1'b0;
         cursorRow <= 5'h01;
         cursorCol <= 7'h01;
         screenSel <= 2'h0;
         // Reset asks the display to blank the whole screen
         clearOp   <= `TEI_CLR_SCR_ALL;
         beep      <= 1'b0;
         selfTest  <= 1'b0;
         txChar    <= 7'h00;
         txValid   <= 1'b0;
         saveRow_q <= 5'h01;
         saveCol_q <= 7'h01;
      end
      else
      begin
         clearOp  <= `TEI_CLR_NONE;
         beep     <= 1'b0;
         selfTest <= 1'b0;
         if (txValid && txReady)
            txValid <= 1'b0;
         if (take)
         begin
            case (st_q)
               ST_IDLE:
               begin
                  case (ch)
                     `TEI_CH_ENQ:
                     begin
                        txChar  <= `TEI_CH_ACK;
                        txValid <= 1'b1;
                     end
                     `TEI_CH_BEL: beep <= 1'b1;
                     `TEI_CH_BS:
                        if (cursorCol > 7'h01)
                           cursorCol <= cursorCol - 7'h01;
                     `TEI_CH_LF:
                        if (cursorRow < `TEI_ROWS)
                           cursorRow <= cursorRow + 5'h01;
                     `TEI_CH_CR: cursorCol <= 7'h01;
                     `TEI_CH_ESC: st_q <= ST_ESC;
                     default: ;
                  endcase
               end
               ST_ESC:
               begin
                  st_q <= ST_IDLE;
                  case (ch)
                     `TEI_CH_LBR:
                     begin
                        st_q     <= ST_CSI;
                        p1_q     <= {PW{1'b0}};
                        p2_q     <= {PW{1'b0}};
                        p1Seen_q <= 1'b0;
                        semi_q   <= 1'b0;
                     end
                     `TEI_CH_SAVE:
                     begin
                        saveRow_q <= cursorRow;
                        saveCol_q <= cursorCol;
                     end
                     `TEI_CH_REST:
                     begin
                        cursorRow <= saveRow_q;
                        cursorCol <= saveCol_q;
                     end
                     // Same code as cursor-left; the state tells them apart
                     `TEI_CH_IDX:
                        if (cursorRow < `TEI_ROWS)
                           cursorRow <= cursorRow + 5'h01;
                        else if (screenSel != `TEI_SCREENS)
                           screenSel <= screenSel + 2'h1;
                     `TEI_CH_NEL:
                     begin
                        cursorCol <= 7'h01;
                        if (cursorRow < `TEI_ROWS)
                           cursorRow <= cursorRow + 5'h01;
                     end
                     `TEI_CH_RIDX:
                        if (cursorRow > 5'h01)
                           cursorRow <= cursorRow - 5'h01;
                        else if (screenSel != 2'h0)
                           screenSel <= screenSel - 2'h1;
                     `TEI_CH_RIS:
                     begin
                        cursorRow <= 5'h01;
                        cursorCol <= 7'h01;
                        screenSel <= 2'h0;
                        // Saved spot is dropped too; a later restore goes home
                        saveRow_q <= 5'h01;
                        saveCol_q <= 7'h01;
                        clearOp   <= `TEI_CLR_SCR_ALL;
                        selfTest  <= 1'b1;
                     end
                     default: ;
                  endcase
               end
               ST_CSI:
               begin
                  if (isDigit)
                  begin
                     // Saturate so long parameters cannot wrap
                     if (!semi_q)
                     begin
                        p1_q <= accA[PW+3:PW] != 4'h0 ? {PW{1'b1}}
                                : accA[PW-1:0];
                        p1Seen_q <= 1'b1;
                     end
                     else
                        p2_q <= accB[PW+3:PW] != 4'h0 ? {PW{1'b1}}
                                : accB[PW-1:0];
                  end
                  else if (ch == `TEI_CH_SEMI)
                     semi_q <= 1'b1;
                  else
                  begin
                     // Any other character ends the sequence
                     st_q <= ST_IDLE;
                     // Moves saturate at the screen edge rather than wrap
                     case (ch)
                        `TEI_CH_UP:
                           cursorRow <= (rowW > cntW) ?
                              cursorRow - cnt[4:0] : 5'h01;
                        `TEI_CH_DOWN:
                           cursorRow <= (rowW + cntW < {3'h0, `TEI_ROWS}) ?
                              cursorRow + cnt[4:0] : `TEI_ROWS;
                        `TEI_CH_RIGHT:
                           cursorCol <= (colW + cntW < {1'h0, `TEI_COLS}) ?
                              cursorCol + cnt[6:0] : `TEI_COLS;
                        `TEI_CH_LEFT:
                           cursorCol <= (colW > cntW) ?
                              cursorCol - cnt[6:0] : 7'h01;
                        `TEI_CH_POSH, `TEI_CH_POSF:
                        begin
                           cursorRow <= (p1W > {3'h0, `TEI_ROWS}) ? `TEI_ROWS
                              : (p1W == 8'h00 ? 5'h01 : p1W[4:0]);
                           cursorCol <= (p2W > {1'h0, `TEI_COLS}) ? `TEI_COLS
                              : (p2W == 8'h00 ? 7'h01 : p2W[6:0]);
                        end
                        `TEI_CH_ESCR:
                        // Blank values above 2 are ignored
                           case (p1W)
                              8'h00: clearOp <= `TEI_CLR_SCR_END;
                              8'h01: clearOp <= `TEI_CLR_SCR_BEG;
                              8'h02: clearOp <= `TEI_CLR_SCR_ALL;
                              default: ;
                           endcase
                        `TEI_CH_ERLN:
                           case (p1W)
                              8'h00: clearOp <= `TEI_CLR_LN_END;
                              8'h01: clearOp <= `TEI_CLR_LN_BEG;
                              8'h02: clearOp <= `TEI_CLR_LN_ALL;
                              default: ;
                           endcase
                        default: ;
                     endcase
                  end
               end
               default: st_q <= ST_IDLE;
            endcase
         end
      end
   end

endmodule // tei_interpreter

// ---- sim/tei_host_model.sv ----
// Host model: sends queued characters, accepts ACK characters.
// Assumes the bench fills q and sets slow or holdTx off the rising edge.
`timescale 1ns/1ns
`include "tei_regs.vh"

module tei_host_model (
   // Clock
   input  wire logic       clk,
   // Characters to the interpreter
   output logic      [6:0] rxChar,
   output logic            rxValid,
   input  wire logic       rxReady,
   // Characters back from it
   input  wire logic [6:0] txChar,
   input  wire logic       txValid,
   output logic            txReady
);
   logic [6:0] q[$];
   logic [6:0] chr_q = 7'h00;
   logic       slow = 0, holdTx = 0, took = 0, ph = 0;
   logic       vld_q = 1'b0, rdy_q = 1'b1;
   int         acks = 0, badAck = 0;

   // Each output has a single procedural driver
   assign rxChar  = chr_q;
   assign rxValid = vld_q;
   assign txReady = rdy_q;

   always @(posedge clk)
   begin
      took <= rxValid && rxReady;
      if (txValid && txReady)
      begin
         acks <= acks + 1;
         if (txChar !== `TEI_CH_ACK) badAck <= badAck + 1;
      end
   end

   // An offer stays until taken; an idle data line flips every cycle
   always @(negedge clk)
   begin
      ph <= ~ph;
      rdy_q <= !holdTx && (!slow || ph);
      if (took) q.delete(0);
      if (q.size() != 0 && ((rxValid && !took) || !slow || ph))
      begin
         vld_q <= 1'b1;
         chr_q <= q[0];
      end
      else
      begin
         vld_q <= 1'b0;
         chr_q <= ~chr_q;
      end
   end
endmodule // tei_host_model

// ---- sim/tei_interpreter_properties.sv ----
// Port checks for the escape interpreter.
// Assumes one clock, clk, and the active-low reset reset_n.
`timescale 1ns/1ns
`include "tei_regs.vh"

module tei_interpreter_properties (
   // Clock and reset
   input wire logic       clk,
   input wire logic       reset_n,
   // Receive and transmit
   input wire logic [6:0] rxChar,
   input wire logic       rxValid,
   input wire logic       rxReady,
   input wire logic [6:0] txChar,
   input wire logic       txValid,
   input wire logic       txReady,
   // Display control
   input wire logic [4:0] cursorRow,
   input wire logic [6:0] cursorCol,
   input wire logic [1:0] screenSel,
   input wire logic [2:0] clearOp,
   input wire logic       beep,
   input wire logic       selfTest
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);

   a_row_bounded: assert property (cursorRow >= 5'h01
      && cursorRow <= 5'h18) else $error("cursor row out of range");
   a_col_bounded: assert property (cursorCol >= 7'h01
      && cursorCol <= 7'h50) else $error("cursor column out of range");
   a_ack_char: assert property ($rose(txValid)
      |-> txChar == `TEI_CH_ACK)
      else $error("transmitted character is not ACK");
   a_ack_holds: assert property (txValid && !txReady |=>
      txValid && $stable(txChar)) else $error("pending ACK dropped");
   a_stall_freezes: assert property (txValid && !txReady |=>
      $stable(cursorRow) && $stable(cursorCol) && $stable(screenSel)
      && clearOp == 3'h0 && !beep) else $error("acted while ACK pending");
   a_beep_quiet: assert property (beep |-> $stable(cursorRow)
      && $stable(cursorCol) && clearOp == 3'h0 && !selfTest)
      else $error("bell moved the cursor or blanked");
   a_clear_code: assert property (clearOp <= 3'h6)
      else $error("blank code out of range");
   a_scroll_step: assert property ($changed(screenSel) |->
      screenSel == $past(screenSel) + 2'h1 || screenSel == 2'h0
      || $past(screenSel) == screenSel + 2'h1) else $error("window jumped");
   a_scroll_edge: assert property ($changed(screenSel)
      && screenSel != 2'h0 |-> cursorRow == 5'h18 || cursorRow == 5'h01)
      else $error("scroll off edge");
   a_selftest_home: assert property (selfTest |-> cursorRow == 1
      && cursorCol == 1 && screenSel == 0) else $error("reset not home");

   c_beep: cover property (beep);
   c_ack_stall: cover property (txValid && !txReady);
   c_scroll: cover property ($changed(screenSel));
   c_selftest: cover property (selfTest);
endmodule // tei_interpreter_properties

bind tei_interpreter tei_interpreter_properties chk (.clk, .reset_n, .rxChar,
   .rxValid, .rxReady, .txChar, .txValid, .txReady, .cursorRow, .cursorCol,
   .screenSel, .clearOp, .beep, .selfTest);

// ---- sim/tb.sv ----
// Self-checking bench for the escape interpreter.
// Assumes the host model feeds characters; pulses are counted here.
`timescale 1ns/1ns
`include "tei_regs.vh"

module tb;
   logic       clk = 0, reset_n = 0;
   wire  [6:0] rxChar, txChar, cursorCol;
   wire        rxValid, rxReady, txValid, txReady, beep, selfTest;
   wire  [4:0] cursorRow;
   wire  [1:0] screenSel;
   wire  [2:0] clearOp;
   int         miscompares = 0, checked = 0, beeps = 0, tests = 0;
   logic [2:0] lastClr = 0;

   always #2 clk = ~clk;

   tei_interpreter uut (.clk, .reset_n, .rxChar, .rxValid, .rxReady, .txChar,
      .txValid, .txReady, .cursorRow, .cursorCol, .screenSel, .clearOp,
      .beep, .selfTest);
   tei_host_model host (.clk, .rxChar, .rxValid, .rxReady, .txChar,
      .txValid, .txReady);

   // One-cycle pulses are caught here so scenarios can check them later
   always @(posedge clk)
      if (reset_n)
      begin
         if (clearOp != 0) lastClr <= clearOp;
         beeps <= beeps + beep;
         tests <= tests + selfTest;
      end

   // -------------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------------
   task automatic end_of_test;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic cmp(input logic [6:0] got, exp, input string what);
      checked++;
      if (got !== exp)
      begin
         miscompares++;
         $display("unexpected at %0t: %s %h not %h", $time, what, got, exp);
      end
   endtask

   task automatic pos(input logic [4:0] r, input logic [6:0] c,
                      input logic [1:0] s);
      cmp(7'(cursorRow), 7'(r), "row");
      cmp(cursorCol, c, "column");
      cmp(7'(screenSel), 7'(s), "screen");
   endtask

   // Hands the string to the host, waits until taken and interpreted
   task automatic send(input string s);
      int n;
      for (n = 0; n < s.len(); n++)
         host.q.push_back(7'(s[n]));
      for (n = 0; n < 400 && (host.q.size() != 0 || rxValid); n++)
         @(negedge clk);
      if (n == 400)
      begin
         miscompares++;
         $display("unexpected at %0t: input not consumed", $time);
         end_of_test();
      end
      repeat (4) @(negedge clk);
   endtask

   // -------------------------------------------------------------------
   // Scenarios
   // -------------------------------------------------------------------
   task automatic t_ctrl;
      pos(1, 1, 0);
      cmp(7'(lastClr), 7'h3, "reset blank");
      send("\033[5;10H\010\012");
      pos(6, 9, 0);
      send("\015\001\002\016\007\007");
      pos(6, 1, 0);
      cmp(7'(beeps), 7'h2, "beeps");
      host.holdTx = 1;
      host.q = '{`TEI_CH_ENQ, 7'h1b, 7'h5b, 7'h32, 7'h3b, 7'h32, 7'h48};
      repeat (30) @(negedge clk);
      cmp(7'(rxReady), 7'h0, "refused while ACK pending");
      host.holdTx = 0;
      host.slow = 1;
      send("");
      pos(2, 2, 0);
      cmp(7'(host.acks), 7'h1, "ack count");
      cmp(7'(host.badAck), 7'h0, "ack code");
      host.slow = 0;
   endtask

   task automatic t_moves;
      send("\033[3;78H\033[5C");
      pos(3, 80, 0);
      send("\033[C");
      pos(3, 80, 0);
      send("\033[0D\033[2D");
      pos(3, 77, 0);
      send("\033[99D\033[D");
      pos(3, 1, 0);
      send("\033[2A\033[A");
      pos(1, 1, 0);
      send("\033[30B\033[B");
      pos(24, 1, 0);
      send("\033[99;99f");
      pos(24, 80, 0);
      send("\033[;5H");
      pos(1, 5, 0);
   endtask

   task automatic t_blank;
      for (int k = 0; k < 6; k++)
      begin
         send($sformatf("\033[%0d%s", k % 3, k < 3 ? "J" : "K"));
         cmp(7'(lastClr), 7'(k + 1), "blank code");
      end
      send("\033[J\033[5J");
      cmp(7'(lastClr), 7'h1, "default blank");
   endtask

   task automatic t_save_scroll;
      send("\033[7;9H\0337\033[2;2H\0338\033[5z\033z");
      pos(7, 9, 0);
      send("\033[24;1H\033D");
      pos(24, 1, 1);
      send("\033D\033D\033D");
      pos(24, 1, 3);
      send("\033[H\033M\033[9A");
      pos(1, 1, 2);
      send("\033E");
      pos(2, 1, 2);
      send("\033M\033M\033M\033M");
      pos(1, 1, 0);
      send("\033[5;5H\0337\033c");
      pos(1, 1, 0);
      cmp(7'(tests), 7'h1, "self test");
      send("\0338");
      pos(1, 1, 0);
   endtask

   initial
   begin
      repeat (12) @(negedge clk);
      reset_n = 1;
      repeat (2) @(negedge clk);
      t_ctrl();
      t_moves();
      t_blank();
      t_save_scroll();
      end_of_test();
   end
endmodule // tb
